// ---- burst_sram_map.vh ----
// address map, field layout and sizing constants of the burst sram port
`ifndef BURST_SRAM_MAP_VH
`define BURST_SRAM_MAP_VH

// word address width, 1M words of 18 bits
`define SRAM_ADDR_W 20
// burst counter width and the upper address field
`define BURST_W 2
`define BASE_W 18
`define BASE_MSB 19
`define BASE_LSB 2
// byte lanes: 8 data bits plus one parity bit each
`define LANES 2
`define LANE_DATA_W 8
`define DATA_W 16
`define LANE_W 9
// write queue entry: {address, lane enables, parity, data}
`define WQ_W 40
`define WQ_ADDR_LSB 20
`define WQ_MASK_LSB 18
`define WQ_PAR_LSB 16
`define WQ_DEPTH 8
`define WQ_PTR_W 3
// burst order strap encoding and its value before capture
`define ORDER_LINEAR 1'b0
`define ORDER_INTERLEAVED 1'b1

`endif

// ---- write_queue.v ----
// show-ahead fifo holding captured writes until the array takes them
`timescale 1ns/10ps

module write_queue
#(
	parameter WIDTH = 40,
	parameter DEPTH = 8,
	parameter PTR_W = 3
)
(
	input wire clk_i,
	input wire rst_b_i,
	input wire in_valid_i,
	output reg in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);

	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [PTR_W-1:0] wr_ptr_r;
	reg [PTR_W-1:0] rd_ptr_r;
	reg [PTR_W:0] count_r;
	wire push;
	wire pop;
	wire [PTR_W:0] count_nxt;

	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_valid_o = (count_r != {(PTR_W+1){1'b0}});
	assign out_data_o = store[rd_ptr_r];
	assign count_nxt = count_r + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};

	// entry storage, no reset needed
	always @(posedge clk_i)
	begin
		if (push)
		begin
			store[wr_ptr_r] <= in_data_i;
		end
	end

	// pointers, fill count and registered ready
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr_r <= {PTR_W{1'b0}};
			rd_ptr_r <= {PTR_W{1'b0}};
			count_r <= {(PTR_W+1){1'b0}};
			in_ready_o <= 1'b1;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_r <= wr_ptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
			end
			if (pop)
			begin
				rd_ptr_r <= rd_ptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
			end
			count_r <= count_nxt;
			in_ready_o <= (count_nxt != DEPTH[PTR_W:0]); // full stalls capture
		end
	end

endmodule // write_queue

// ---- burst_sram_port.v ----
// pipelined burst sram: synchronous host port, burst counter and storage
`timescale 1ns/10ps
`include "burst_sram_map.vh"

// Notes on behaviour
// [RQ1] all synchronous inputs are taken only on the rising clock edge
// [RQ2] during a burst, burst step low at an edge advances the burst address
// [RQ3] first select is active low; selection needs all three selects true
// [RQ4] second select is active high, sampled on the edge, joins selection
// [RQ5] third select is active low, sampled; tie it low where absent
// [RQ6] processor strobe ignored whenever first select is high at that edge
// [RQ7] accepted strobe loads full address; low two bits seed burst counter
// [RQ8] both strobes low together: only the processor strobe acts; here, with first select high, the controller strobe acts instead
// [RQ9] output enable is asynchronous, active low; high floats data and parity
// [RQ10] first clock of a read after deselect keeps data outputs off
// [RQ11] read data is registered, from address of the previous edge
// [RQ12] write data lines are captured into a data register on the edge
// [RQ13] sleep high gives low power, contents kept; hold low for normal use
// [RQ14] order strap low gives linear bursts, high gives interleaved
// [RQ15] burst counter is two bits, keeps start, wraps within four beats
// [RQ16] all-byte write low writes every lane regardless of lane controls
// [RQ17] a lane is written when qualifier and its lane select are both low
// [RQ18] linear adds beat modulo four; interleaved xors start with beat
module burst_sram_port
(
	input wire CLK_I,
	input wire RST_B_I,
	input wire [19:0] ADDR_I,
	input wire CHIP_SELECT_FIRST_N_I,
	input wire CHIP_SELECT_SECOND_I,
	input wire CHIP_SELECT_THIRD_N_I,
	input wire CPU_ADDR_STROBE_N_I,
	input wire CTRL_ADDR_STROBE_N_I,
	input wire BURST_STEP_N_I,
	input wire ALL_BYTE_WRITE_N_I,
	input wire BYTE_WRITE_QUALIFY_N_I,
	input wire [1:0] BYTE_LANE_SELECT_N_I,
	input wire OUT_ENABLE_N_I,
	input wire SLEEP_REQUEST_I,
	input wire BURST_ORDER_I,
	input wire [15:0] DQ_I,
	input wire [1:0] PARITY_LANES_I,
	output reg [15:0] DQ_O,
	output reg [1:0] PARITY_LANES_O,
	output wire DATA_OE_N_O,
	output wire WRITE_READY_O,
	output reg SLEEP_ACTIVE_O
);

	// selection and strobe arbitration
	wire selected;
	wire take_cpu;
	wire take_ctrl;
	wire start;
	wire awake;
	// burst state
	reg active_r;
	reg active_nxt;
	reg [`BASE_W-1:0] base_r;
	reg [`BASE_W-1:0] base_nxt;
	reg [`BURST_W-1:0] first_r;
	reg [`BURST_W-1:0] first_nxt;
	reg [`BURST_W-1:0] beat_r;
	reg [`BURST_W-1:0] beat_nxt;
	reg [`BURST_W-1:0] low_nxt;
	reg order_r;
	reg strap_taken_r;
	// access requests of this edge
	wire [`LANES-1:0] lane_wr;
	wire any_lane;
	wire in_burst;
	wire wr_req;
	wire rd_req;
	wire [`SRAM_ADDR_W-1:0] cur_addr;
	// read pipeline
	reg [`SRAM_ADDR_W-1:0] rd_addr_r;
	reg rd_pend_r;
	reg drive_r;
	// write queue interface
	wire wq_ready;
	wire wq_out_valid;
	wire wq_out_ready;
	wire [`WQ_W-1:0] wq_in;
	wire [`WQ_W-1:0] wq_out;
	wire [`SRAM_ADDR_W-1:0] wq_addr;
	wire [`LANES-1:0] wq_mask;

	// sleep blocks every new access; the array state is untouched
	assign awake = ~SLEEP_REQUEST_I; // [RQ13]

	// device is selected only when all three selects are true
	assign selected = ~CHIP_SELECT_FIRST_N_I // [RQ3]
		& CHIP_SELECT_SECOND_I // [RQ4]
		& ~CHIP_SELECT_THIRD_N_I; // [RQ5]

	// processor strobe needs first select low and beats controller strobe
	assign take_cpu = awake & ~CPU_ADDR_STROBE_N_I & ~CHIP_SELECT_FIRST_N_I; // [RQ6]
	assign take_ctrl = awake & ~CTRL_ADDR_STROBE_N_I & ~take_cpu; // [RQ8]
	assign start = take_cpu | take_ctrl;

	// lane write enables from the write controls
	genvar g;
	generate
		for (g = 0; g < `LANES; g = g + 1)
		begin : lane_en
			assign lane_wr[g] = ~ALL_BYTE_WRITE_N_I // [RQ16]
				| (~BYTE_WRITE_QUALIFY_N_I & ~BYTE_LANE_SELECT_N_I[g]); // [RQ17]
		end
	endgenerate
	assign any_lane = |lane_wr;

	// burst counter: load on an accepted strobe, step on burst step low
	always @*
	begin
		active_nxt = active_r;
		base_nxt = base_r;
		first_nxt = first_r;
		beat_nxt = beat_r;
		if (start)
		begin
			active_nxt = selected; // [RQ3]
			if (selected)
			begin
				base_nxt = ADDR_I[`BASE_MSB:`BASE_LSB]; // [RQ7]
				first_nxt = ADDR_I[`BURST_W-1:0]; // [RQ7]
				beat_nxt = {`BURST_W{1'b0}};
			end
		end
		else if (awake && active_r && !BURST_STEP_N_I)
		begin
			beat_nxt = beat_r + {{(`BURST_W-1){1'b0}}, 1'b1}; // [RQ2] [RQ15]
		end
		if (order_r == `ORDER_LINEAR)
		begin
			low_nxt = first_nxt + beat_nxt; // [RQ18] [RQ14]
		end
		else
		begin
			low_nxt = first_nxt ^ beat_nxt; // [RQ18] [RQ14]
		end
	end

	assign cur_addr = {base_nxt, low_nxt};

	// a cycle inside a selected burst, or a fresh selected start
	assign in_burst = awake & ((start & selected) | (~start & active_r));

	// processor strobe starts are reads; write controls count elsewhere
	assign wr_req = in_burst & ~take_cpu & any_lane;
	assign rd_req = in_burst & ~wr_req;

	// captured write: address, lane enables and the data lines of this edge
	assign wq_in = {cur_addr, lane_wr, PARITY_LANES_I, DQ_I}; // [RQ12]

	// queue drains into the array one entry per clock while awake
	assign wq_out_ready = awake;
	assign wq_addr = wq_out[`WQ_W-1:`WQ_ADDR_LSB];
	assign wq_mask = wq_out[`WQ_ADDR_LSB-1:`WQ_MASK_LSB];

	write_queue
	#(
		.WIDTH(`WQ_W),
		.DEPTH(`WQ_DEPTH),
		.PTR_W(`WQ_PTR_W)
	)
	u_write_queue
	(
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.in_valid_i(wr_req),
		.in_ready_o(wq_ready),
		.in_data_i(wq_in),
		.out_valid_o(wq_out_valid),
		.out_ready_i(wq_out_ready),
		.out_data_o(wq_out)
	);

	assign WRITE_READY_O = wq_ready;

	// burst state, strap capture and read pipeline registers
	always @(posedge CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			active_r <= 1'b0;
			base_r <= {`BASE_W{1'b0}};
			first_r <= {`BURST_W{1'b0}};
			beat_r <= {`BURST_W{1'b0}};
			order_r <= `ORDER_INTERLEAVED;
			strap_taken_r <= 1'b0;
			rd_addr_r <= {`SRAM_ADDR_W{1'b0}};
			rd_pend_r <= 1'b0;
			drive_r <= 1'b0;
			SLEEP_ACTIVE_O <= 1'b0;
		end
		else
		begin
			active_r <= active_nxt; // [RQ1]
			base_r <= base_nxt;
			first_r <= first_nxt;
			beat_r <= beat_nxt;
			// order strap is caught once, at the first edge after reset
			if (!strap_taken_r)
			begin
				order_r <= BURST_ORDER_I; // [RQ14]
				strap_taken_r <= 1'b1;
			end
			rd_addr_r <= cur_addr;
			rd_pend_r <= rd_req;
			// drive only once read data is out; after deselect it starts off
			drive_r <= rd_pend_r & awake; // [RQ10] [RQ11]
			SLEEP_ACTIVE_O <= SLEEP_REQUEST_I; // [RQ13]
		end
	end

	// storage and unregistered read word per byte lane
	generate
		for (g = 0; g < `LANES; g = g + 1)
		begin : lane_mem
			reg [`LANE_W-1:0] cells [0:(1<<`SRAM_ADDR_W)-1];
			wire [`LANE_W-1:0] rd_word;
			wire [`LANE_W-1:0] wdata;

			assign wdata = {wq_out[`WQ_PAR_LSB+g],
				wq_out[g*`LANE_DATA_W +: `LANE_DATA_W]};

			// array write from the queue head
			always @(posedge CLK_I)
			begin
				if (wq_out_valid && wq_out_ready && wq_mask[g])
				begin
					cells[wq_addr] <= wdata; // [RQ16] [RQ17]
				end
			end

			// lane word at the address taken at the previous edge
			assign rd_word = cells[rd_addr_r]; // [RQ11]
		end
	endgenerate

	// output data registers collected from the lanes
	always @(posedge CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			DQ_O <= {`DATA_W{1'b0}};
			PARITY_LANES_O <= {`LANES{1'b0}};
		end
		else
		begin
			DQ_O <= DQ_O;
			PARITY_LANES_O <= PARITY_LANES_O;
			if (rd_pend_r)
			begin
				DQ_O <= {lane_mem[1].rd_word[`LANE_DATA_W-1:0],
					lane_mem[0].rd_word[`LANE_DATA_W-1:0]}; // [RQ11]
				PARITY_LANES_O <= {lane_mem[1].rd_word[`LANE_DATA_W],
					lane_mem[0].rd_word[`LANE_DATA_W]};
			end
		end
	end

	// output enable acts without the clock; sleep floats the pins too
	assign DATA_OE_N_O = ~(drive_r & ~OUT_ENABLE_N_I & ~SLEEP_REQUEST_I); // [RQ9] [RQ13]

endmodule // burst_sram_port

// ---- burst_sram_port_monitor.sv ----
// concurrent checks on the burst sram host port
`timescale 1ns/10ps
module burst_sram_port_monitor
(
	input logic CLK_I,
	input logic RST_B_I,
	input logic CHIP_SELECT_FIRST_N_I,
	input logic CHIP_SELECT_SECOND_I,
	input logic CHIP_SELECT_THIRD_N_I,
	input logic CPU_ADDR_STROBE_N_I,
	input logic CTRL_ADDR_STROBE_N_I,
	input logic BURST_STEP_N_I,
	input logic ALL_BYTE_WRITE_N_I,
	input logic BYTE_WRITE_QUALIFY_N_I,
	input logic OUT_ENABLE_N_I,
	input logic SLEEP_REQUEST_I,
	input logic DATA_OE_N_O,
	input logic SLEEP_ACTIVE_O
);
	// decoded requests at each edge
	wire sel = !CHIP_SELECT_FIRST_N_I && CHIP_SELECT_SECOND_I && !CHIP_SELECT_THIRD_N_I;
	wire cpu = !CPU_ADDR_STROBE_N_I && !CHIP_SELECT_FIRST_N_I;
	wire ctl = !CTRL_ADDR_STROBE_N_I && !cpu;
	wire awake = !SLEEP_REQUEST_I && !SLEEP_ACTIVE_O;
	wire rd = awake && sel && (cpu || ctl && ALL_BYTE_WRITE_N_I && BYTE_WRITE_QUALIFY_N_I);
	wire shown = OUT_ENABLE_N_I || SLEEP_REQUEST_I || !DATA_OE_N_O;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	a_oe_float: assert property (OUT_ENABLE_N_I |-> DATA_OE_N_O)
		else $error("data driven with output enable off");
	a_sleep_float: assert property (SLEEP_REQUEST_I |-> DATA_OE_N_O)
		else $error("data driven while asleep");
	a_sleep_flag: assert property ($rose(SLEEP_REQUEST_I) |=> SLEEP_ACTIVE_O)
		else $error("sleep not reported");
	a_read_drive: assert property (rd ##1 awake |-> ##1 shown)
		else $error("read data not driven one clock later");
	a_cpu_wins: assert property (awake && sel && cpu && !CTRL_ADDR_STROBE_N_I
		&& !ALL_BYTE_WRITE_N_I ##1 awake |-> ##1 shown)
		else $error("processor strobe did not win");
	a_write_quiet: assert property (awake && sel && ctl && !ALL_BYTE_WRITE_N_I
		|-> ##2 DATA_OE_N_O)
		else $error("write cycle drove data");
	a_deselect_quiet: assert property (awake && !sel && (cpu || !CTRL_ADDR_STROBE_N_I)
		|-> ##2 DATA_OE_N_O)
		else $error("deselect cycle drove data");
	a_step_read: assert property (rd ##1 (awake && CPU_ADDR_STROBE_N_I && CTRL_ADDR_STROBE_N_I
		&& !BURST_STEP_N_I && ALL_BYTE_WRITE_N_I && BYTE_WRITE_QUALIFY_N_I) ##1 awake
		|-> ##1 shown)
		else $error("burst step gave no read");
endmodule // burst_sram_port_monitor

// ---- host_port_model.sv ----
// host side model: drives port controls and the shared data lines
`timescale 1ns/10ps
module host_port_model
(
	input logic clk_i,
	output logic [9:0] ctl_o,
	output logic [19:0] addr_o,
	output logic [17:0] dq_o
);
	// idle as a deselect, data lines released
	initial
	begin
		ctl_o = 10'h05F;
		addr_o = 20'h00000;
		dq_o = 18'h2AAAA;
	end
	// one request per edge; first select moves with the strobes
	task automatic cyc(input logic [9:0] c, input logic [19:0] a, input logic [17:0] d);
		@(posedge clk_i);
		ctl_o <= c;
		addr_o <= a;
		// a released bus shows the inverse of its previous value
		if (!c[3] || !c[2])
			dq_o <= d;
		else
			dq_o <= ~dq_o;
	endtask
endmodule // host_port_model

// ---- burst_sram_port_tb_top.sv ----
// self-checking bench for the burst sram host port
`timescale 1ns/10ps
module burst_sram_port_tb_top;
	localparam logic [9:0] DS = 10'h05F, CR = 10'h13F, WA = 10'h157, L0 = 10'h15A;
	localparam logic [9:0] NQ = 10'h15C, ST = 10'h16F, NP = 10'h17F, BO = 10'h117;
	localparam logic [9:0] C1H = 10'h33F, C3H = 10'h1DF;
	logic clk, rst_b, oe_n, sleep, order, dq_oe_n, wr_rdy, slp_act;
	logic [9:0] ctl;
	logic [19:0] addr;
	logic [17:0] dq;
	logic [15:0] dq_o;
	logic [1:0] par_o;
	logic [17:0] got[$];
	int fail_count, n_tests, cycles;
	burst_sram_port dut
	(
		.CLK_I(clk),
		.RST_B_I(rst_b),
		.ADDR_I(addr),
		.CHIP_SELECT_FIRST_N_I(ctl[9]),
		.CHIP_SELECT_SECOND_I(ctl[8]),
		.CHIP_SELECT_THIRD_N_I(ctl[7]),
		.CPU_ADDR_STROBE_N_I(ctl[6]),
		.CTRL_ADDR_STROBE_N_I(ctl[5]),
		.BURST_STEP_N_I(ctl[4]),
		.ALL_BYTE_WRITE_N_I(ctl[3]),
		.BYTE_WRITE_QUALIFY_N_I(ctl[2]),
		.BYTE_LANE_SELECT_N_I(ctl[1:0]),
		.OUT_ENABLE_N_I(oe_n),
		.SLEEP_REQUEST_I(sleep),
		.BURST_ORDER_I(order),
		.DQ_I(dq[15:0]),
		.PARITY_LANES_I(dq[17:16]),
		.DQ_O(dq_o),
		.PARITY_LANES_O(par_o),
		.DATA_OE_N_O(dq_oe_n),
		.WRITE_READY_O(wr_rdy),
		.SLEEP_ACTIVE_O(slp_act)
	);
	host_port_model host
	(
		.clk_i(clk),
		.ctl_o(ctl),
		.addr_o(addr),
		.dq_o(dq)
	);
	// 8 ns clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// collect every word driven onto the data lines
	always @(negedge clk)
		if (dq_oe_n === 1'b0)
			got.push_back({par_o, dq_o});
	// cut a hung run short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			close_out();
		end
	end
	// shared helpers
	function automatic logic [17:0] val(input logic [7:0] i);
		return {i[1:0], 8'hC3, i};
	endfunction
	task automatic flush();
		repeat (4) host.cyc(DS, 20'h00000, 18'h00000);
	endtask
	task automatic chk(input logic [17:0] e);
		n_tests++;
		if (got.size() == 0 || got[0] !== e)
		begin
			fail_count++;
			$display("mismatch at %0t: expected %h", $time, e);
		end
		if (got.size() != 0)
			void'(got.pop_front());
	endtask
	task automatic done(input string s);
		n_tests++;
		if (got.size() != 0 || wr_rdy !== 1'b1)
		begin
			fail_count++;
			$display("mismatch at %0t: %0d extra words", $time, got.size());
		end
		got.delete();
		$display("test %s done", s);
	endtask
	task automatic reset_with(input logic o);
		@(posedge clk);
		rst_b <= 1'b0;
		order <= o;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	// full write, lane write, blocked lane write that reads instead
	task automatic t_write();
		host.cyc(WA, 20'h00100, val(8'h11));
		host.cyc(L0, 20'h00100, val(8'h22));
		host.cyc(NQ, 20'h00100, val(8'h33));
		host.cyc(CR, 20'h00100, 18'h00000);
		flush();
		chk({2'b00, 8'hC3, 8'h22});
		chk({2'b00, 8'hC3, 8'h22});
		done("write");
	endtask
	// strobe priority, ignored strobe, third select off
	task automatic t_strobe();
		host.cyc(WA, 20'h00300, val(8'h44));
		host.cyc(BO, 20'h00300, val(8'h55));
		host.cyc(C1H, 20'h00301, val(8'h66));
		flush();
		host.cyc(CR, 20'h00300, 18'h00000);
		flush();
		host.cyc(C3H, 20'h00300, 18'h00000);
		flush();
		repeat (3) chk(val(8'h44));
		done("strobes");
	endtask
	// output enable off, then sleep keeps contents and ignores a write
	task automatic t_quiet();
		oe_n <= 1'b1;
		host.cyc(CR, 20'h00300, 18'h00000);
		flush();
		oe_n <= 1'b0;
		sleep <= 1'b1;
		host.cyc(WA, 20'h00300, val(8'h77));
		host.cyc(CR, 20'h00300, 18'h00000);
		flush();
		@(negedge clk);
		n_tests++;
		if (slp_act !== 1'b1)
		begin
			fail_count++;
			$display("mismatch at %0t: sleep flag low", $time);
		end
		@(posedge clk);
		sleep <= 1'b0;
		flush();
		host.cyc(CR, 20'h00300, 18'h00000);
		flush();
		chk(val(8'h44));
		done("quiet");
	endtask
	// burst from start 1 with a held beat, order per strap
	task automatic t_burst();
		logic [1:0] b, ix;
		for (int i = 0; i < 4; i++)
			host.cyc(WA, {18'h00080, i[1:0]}, val({6'h00, i[1:0]}));
		host.cyc(CR, 20'h00201, 18'h00000);
		host.cyc(ST, 20'h00000, 18'h00000);
		host.cyc(NP, 20'h00000, 18'h00000);
		host.cyc(ST, 20'h00000, 18'h00000);
		host.cyc(ST, 20'h00000, 18'h00000);
		flush();
		for (int j = 0; j < 5; j++)
		begin
			b = 2'(j - (j > 1));
			ix = order ? (2'd1 ^ b) : (2'd1 + b);
			chk(val({6'h00, ix}));
		end
		done("burst");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		rst_b = 1'b0;
		oe_n = 1'b0;
		sleep = 1'b0;
		order = 1'b0;
		fail_count = 0;
		n_tests = 0;
		cycles = 0;
		reset_with(1'b0);
		t_write();
		t_strobe();
		t_quiet();
		t_burst();
		reset_with(1'b1);
		t_burst();
		close_out();
	end
endmodule // burst_sram_port_tb_top
bind burst_sram_port burst_sram_port_monitor mon (.*);
